// ==== tb/rx_checker.sv ====
// Port-level assertions for the serial receiver
`timescale 1ns/1ps
`default_nettype none
module rx_checker (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic rvalid,
    input wire logic rready,
    // Pins
    input wire logic transmit_pin,
    input wire logic irq,
    input wire logic irq_high_priority
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_write_answer: assert property (awvalid && awready && wvalid && wready
        |=> ##1 bvalid) else $error("write not answered");
    a_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write answer dropped");
    a_read_answer: assert property (arvalid && arready |=> rvalid)
        else $error("read not answered");
    a_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read answer dropped");
    a_write_busy: assert property (bvalid |-> !awready && !wready)
        else $error("write taken while busy");
    a_read_busy: assert property (rvalid |-> !arready)
        else $error("read taken while busy");
    a_resp_legal: assert property (bvalid |-> bresp == 2'h0 || bresp == 2'h2)
        else $error("bad write response");
    a_tx_level_write: assert property ($changed(transmit_pin) |->
        bvalid || $past(bvalid) || $past(bvalid, 2))
        else $error("transmit level moved without write");
    a_prio_write: assert property ($changed(irq_high_priority) |->
        bvalid || $past(bvalid) || $past(bvalid, 2))
        else $error("priority moved without write");
    c_write: cover property (bvalid && bready);
    c_read: cover property (rvalid && rready);
    c_irq: cover property ($rose(irq));
endmodule // rx_checker
bind async_receiver_address_detect rx_checker i_chk (.aclk, .aresetn,
    .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid, .bready,
    .arvalid, .arready, .rdata, .rvalid, .rready, .transmit_pin, .irq,
    .irq_high_priority);
`default_nettype wire

// ==== tb/serial_node_model.sv ====
// Remote node that drives frames onto the receive line
`timescale 1ns/1ps
`default_nettype none
module serial_node_model #(
    parameter int BIT = 16
) (
    // Clock
    input wire logic aclk,
    // Line
    output logic receive_pin
);
    logic inv = 1'b0;
    initial receive_pin = 1'b1;
    task automatic set_polarity(input logic p);
        inv = p;
        receive_pin <= ~p;
    endtask
    // Start, n data bits LSB first, stop; a bad stop is short
    task automatic send(input logic [8:0] d, input int n, input logic s);
        logic b;
        for (int i = 0; i < n + 2; i++) begin
            b = (i == 0) ? 1'b0 : (i == n + 1) ? s : d[i-1];
            receive_pin <= b ^ inv;
            repeat ((i == n + 1 && !s) ? BIT * 10 / 16 : BIT) @(posedge aclk);
        end
        receive_pin <= ~inv;
        repeat (BIT) @(posedge aclk);
    endtask
endmodule // serial_node_model
`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking bench for the serial receiver
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [2:0] awprot = 3'h0, arprot = 3'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] wstrb = 4'hF;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic receive_pin, transmit_pin, transmit_pin_oe, irq, irq_high_priority;
    int mismatches = 0, checks = 0;
    logic [31:0] v;
    logic [1:0] r;
    always #4 aclk = ~aclk;
    async_receiver_address_detect i_dut (.aclk, .aresetn, .awaddr, .awprot,
        .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
        .bready, .araddr, .arprot, .arvalid, .arready, .rdata, .rresp, .rvalid,
        .rready, .receive_pin, .transmit_pin, .transmit_pin_oe, .irq,
        .irq_high_priority);
    serial_node_model #(.BIT(16)) i_node (.aclk, .receive_pin);
    // ------------------------------------------------------------
    // Bus and compare helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] s, e, input string m);
        checks++;
        if (s !== e) begin
            mismatches++;
            $display("[FAIL] %0t %s: %h not %h", $time, m, s, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
        end while (bvalid !== 1'b1);
        r = bresp;
        bready <= 0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 0;
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        rd(a, v);
        chk(v, e, "register read");
    endtask
    task automatic settle();
        repeat (2) @(posedge aclk);
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        rdc(8'h00, 32'h0);
        rdc(8'h08, 32'h0);
        rdc(8'h1C, 32'h0);
        chk(r, 2'h2, "unmapped answer");
        wr(8'h1C, 32'hFFFF_FFFF);
        chk(r, 2'h2, "unmapped write answer");
        wr(8'h08, 32'h0000_0000);
        chk(r, 2'h0, "mapped write answer");
        $display("test reset done");
    endtask
    task automatic t_plain();
        wr(8'h08, 32'h0001_0000);
        wr(8'h00, 32'hA0);
        i_node.send(9'h05A, 8, 1);
        rdc(8'h10, 32'h0);
        rdc(8'h00, 32'hA0);
        wr(8'h00, 32'h90);
        i_node.send(9'h0A5, 8, 1);
        rdc(8'h10, 32'h1);
        rdc(8'h00, 32'h90);
        rdc(8'h04, 32'hA5);
        wr(8'h14, 32'h1);
        $display("test eight-bit done");
    endtask
    task automatic t_addr();
        wr(8'h00, 32'hD8);
        i_node.send(9'h033, 9, 1);
        rdc(8'h10, 32'h0);
        i_node.send(9'h155, 9, 1);
        rdc(8'h00, 32'hD9);
        rdc(8'h04, 32'h55);
        wr(8'h14, 32'h1);
        wr(8'h00, 32'hD0);
        i_node.send(9'h066, 9, 1);
        rdc(8'h00, 32'hD0);
        rdc(8'h04, 32'h66);
        wr(8'h14, 32'h1);
        wr(8'h00, 32'h98);
        i_node.send(9'h033, 8, 1);
        rdc(8'h10, 32'h1);
        rdc(8'h04, 32'h33);
        wr(8'h14, 32'h1);
        $display("test address detect done");
    endtask
    task automatic t_err();
        wr(8'h00, 32'h90);
        i_node.send(9'h011, 8, 1);
        i_node.send(9'h022, 8, 1);
        rdc(8'h00, 32'h92);
        wr(8'h00, 32'h80);
        rdc(8'h00, 32'h80);
        rdc(8'h04, 32'h11);
        wr(8'h00, 32'h90);
        i_node.send(9'h0C3, 8, 0);
        rdc(8'h00, 32'h94);
        rdc(8'h04, 32'hC3);
        wr(8'h00, 32'h80);
        wr(8'h14, 32'h7);
        $display("test errors done");
    endtask
    task automatic t_pol();
        wr(8'h00, 32'h00);
        wr(8'h08, 32'h000D_0000);
        i_node.set_polarity(1);
        wr(8'h0C, 32'h3);
        wr(8'h18, 32'h1);
        settle();
        chk(transmit_pin, 1'b0, "transmit idle");
        chk(transmit_pin_oe, 1'b0, "pin released");
        chk(irq_high_priority, 1'b1, "priority");
        chk(irq, 1'b0, "irq idle");
        wr(8'h00, 32'h90);
        i_node.send(9'h03C, 8, 1);
        rdc(8'h04, 32'h3C);
        chk(transmit_pin_oe, 1'b1, "pin driven");
        chk(irq, 1'b1, "irq raised");
        wr(8'h0C, 32'h2);
        settle();
        chk(irq, 1'b0, "irq global off");
        wr(8'h0C, 32'h1);
        wr(8'h14, 32'h1);
        settle();
        chk(irq, 1'b0, "irq cleared");
        $display("test polarity done");
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_plain();
        t_addr();
        t_err();
        t_pol();
        finish_test();
    end
    initial begin
        repeat (30000) @(posedge aclk);
        mismatches++;
        finish_test();
    end
endmodule // tb_top
`default_nettype wire

// ==== verilog/async_receiver_address_detect.v ====
// Serial receiver with address detect behind an AXI4-Lite slave
`timescale 1ns/1ps
`default_nettype none
`include "rx_addr_defines.vh"

module async_receiver_address_detect (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // AXI4-Lite write address
    input wire [7:0] awaddr,
    input wire [2:0] awprot,
    input wire awvalid,
    output reg awready,
    // AXI4-Lite write data
    input wire [31:0] wdata,
    input wire [3:0] wstrb,
    input wire wvalid,
    output reg wready,
    // AXI4-Lite write response
    output reg [1:0] bresp,
    output reg bvalid,
    input wire bready,
    // AXI4-Lite read address
    input wire [7:0] araddr,
    input wire [2:0] arprot,
    input wire arvalid,
    output reg arready,
    // AXI4-Lite read data
    output reg [31:0] rdata,
    output reg [1:0] rresp,
    output reg rvalid,
    input wire rready,
    // Serial pins
    input wire receive_pin,
    output reg transmit_pin,
    output reg transmit_pin_oe,
    // Interrupt
    output reg irq,
    output reg irq_high_priority
);

// ----------------------------------------------------------------
// Registers
// ----------------------------------------------------------------
reg port_enable;
reg nine_bit_receive_select;
reg single_receive_enable;
reg continuous_receive_enable;
reg address_detect_enable;
reg framing_error_flag;
reg overrun_error_flag;
reg received_ninth_bit;
reg [7:0] received_data_register;
reg buffer_full;
reg [20:0] baud_config;
reg global_interrupt_enable;
reg receive_priority;
reg [2:0] int_status;
reg [2:0] int_enable;

reg [7:0] aw_addr_q;
reg [31:0] w_data_q;
reg [3:0] w_strb_q;

wire [15:0] divisor = baud_config[15:0];
wire high_speed_rate_select = baud_config[`BIT_HIGH_SPEED];
wire wide_divisor_select = baud_config[`BIT_WIDE_DIVISOR];
wire receive_polarity_invert = baud_config[`BIT_RX_INVERT];
wire transmit_polarity_invert = baud_config[`BIT_TX_INVERT];
wire sync_mode_select = baud_config[`BIT_SYNC_MODE];
wire receive_complete_flag = int_status[`EV_RX_COMPLETE];
wire receive_interrupt_enable = int_enable[`EV_RX_COMPLETE];

// Single receive plays no part here: async receiver only
wire rx_run = port_enable && !sync_mode_select &&
    continuous_receive_enable;

wire [7:0] status_control = {port_enable, nine_bit_receive_select,
    single_receive_enable, continuous_receive_enable,
    address_detect_enable, framing_error_flag, overrun_error_flag,
    received_ninth_bit};

function [31:0] merge;
    input [31:0] old;
    input [31:0] din;
    input [3:0] strb;
    integer i;
    begin
        merge = old;
        for (i = 0; i < 4; i = i + 1)
            if (strb[i])
                merge[i*8 +: 8] = din[i*8 +: 8];
    end
endfunction

function mapped;
    input [7:0] a;
    begin
        mapped = (a == `OFS_STATUS_CONTROL) || (a == `OFS_RX_DATA) ||
            (a == `OFS_BAUD_CONFIG) || (a == `OFS_INT_CONTROL) ||
            (a == `OFS_INT_STATUS) || (a == `OFS_INT_CLEAR) ||
            (a == `OFS_INT_ENABLE);
    end
endfunction

// ----------------------------------------------------------------
// Receive path
// ----------------------------------------------------------------
wire tick16;
wire frame_done;
wire [8:0] frame_data;
wire stop_bad;

baud_tick_gen u_baud (
    .aclk(aclk),
    .aresetn(aresetn),
    .enable(rx_run),
    .divisor(divisor),
    .high_speed(high_speed_rate_select),
    .wide(wide_divisor_select),
    .tick(tick16)
);

rx_frame_shifter u_shift (
    .aclk(aclk),
    .aresetn(aresetn),
    .enable(rx_run),
    .tick16(tick16),
    .invert(receive_polarity_invert),
    .nine_bit(nine_bit_receive_select),
    .receive_pin(receive_pin),
    .frame_done(frame_done),
    .frame_data(frame_data),
    .stop_bad(stop_bad)
);

// Address filter counts only with nine-bit frames
wire addr_mode = address_detect_enable && nine_bit_receive_select;
wire keep = frame_done && rx_run && !overrun_error_flag &&
    (!addr_mode || frame_data[8]);
wire load = keep && !buffer_full;
wire overrun = keep && buffer_full;

// ----------------------------------------------------------------
// Bus handshakes
// ----------------------------------------------------------------
wire aw_take = awvalid && awready;
wire w_take = wvalid && wready;
wire do_write = !awready && !wready && !bvalid;
wire ar_take = arvalid && arready;
wire pop = ar_take && (araddr == `OFS_RX_DATA) && buffer_full;
wire [31:0] wr_word = merge(32'h00000000, w_data_q, w_strb_q);
wire [31:0] baud_word = merge({11'h000, baud_config}, w_data_q, w_strb_q);

reg [31:0] next_rdata;
always @* begin
    next_rdata = 32'h00000000;
    case (araddr)
        `OFS_STATUS_CONTROL: next_rdata[7:0] = status_control;
        `OFS_RX_DATA: next_rdata[7:0] = received_data_register;
        `OFS_BAUD_CONFIG: next_rdata[20:0] = baud_config;
        `OFS_INT_CONTROL: begin
            next_rdata[`BIT_GLOBAL_IE] = global_interrupt_enable;
            next_rdata[`BIT_RX_PRIORITY] = receive_priority;
        end
        `OFS_INT_STATUS: next_rdata[2:0] = int_status;
        `OFS_INT_ENABLE: next_rdata[2:0] = int_enable;
        default: next_rdata = 32'h00000000;
    endcase
end

always @(posedge aclk) begin
    if (!aresetn) begin
        awready <= 1'b1;
        wready <= 1'b1;
        bvalid <= 1'b0;
        bresp <= `RESP_OKAY;
        arready <= 1'b1;
        rvalid <= 1'b0;
        rresp <= `RESP_OKAY;
        rdata <= 32'h00000000;
        aw_addr_q <= 8'h00;
        w_data_q <= 32'h00000000;
        w_strb_q <= 4'h0;
    end else begin
        if (aw_take) begin
            awready <= 1'b0;
            aw_addr_q <= awaddr;
        end
        if (w_take) begin
            wready <= 1'b0;
            w_data_q <= wdata;
            w_strb_q <= wstrb;
        end
        if (do_write) begin
            bvalid <= 1'b1;
            bresp <= mapped(aw_addr_q) ? `RESP_OKAY : `RESP_SLVERR;
        end
        if (bvalid && bready) begin
            bvalid <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
        end
        if (ar_take) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= next_rdata;
            rresp <= mapped(araddr) ? `RESP_OKAY : `RESP_SLVERR;
        end
        if (rvalid && rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
        end
    end
end

// ----------------------------------------------------------------
// Control, buffer and status
// ----------------------------------------------------------------
wire wr_sc = do_write && aw_addr_q == `OFS_STATUS_CONTROL;
wire wr_clr = do_write && aw_addr_q == `OFS_INT_CLEAR;
wire [2:0] events = {overrun, load && stop_bad, load};

always @(posedge aclk) begin
    if (!aresetn) begin
        {port_enable, nine_bit_receive_select, single_receive_enable,
            continuous_receive_enable, address_detect_enable,
            framing_error_flag, overrun_error_flag,
            received_ninth_bit} <= `STATUS_CONTROL_RESET;
        received_data_register <= 8'h00;
        buffer_full <= 1'b0;
        baud_config <= `BAUD_CONFIG_RESET;
        global_interrupt_enable <= 1'b0;
        receive_priority <= 1'b0;
        int_status <= `EV_RESET;
        int_enable <= `EV_RESET;
    end else begin
        if (wr_sc && w_strb_q[0]) begin
            port_enable <= w_data_q[`BIT_PORT_ENABLE];
            nine_bit_receive_select <= w_data_q[`BIT_NINE_BIT];
            single_receive_enable <= w_data_q[`BIT_SINGLE_RX];
            continuous_receive_enable <= w_data_q[`BIT_CONT_RX];
            address_detect_enable <= w_data_q[`BIT_ADDR_DETECT];
        end
        if (do_write && aw_addr_q == `OFS_BAUD_CONFIG)
            baud_config <= baud_word[20:0];
        if (do_write && aw_addr_q == `OFS_INT_CONTROL &&
                w_strb_q[0]) begin
            global_interrupt_enable <= w_data_q[`BIT_GLOBAL_IE];
            receive_priority <= w_data_q[`BIT_RX_PRIORITY];
        end
        if (do_write && aw_addr_q == `OFS_INT_ENABLE && w_strb_q[0])
            int_enable <= w_data_q[2:0];
        // A new event wins over a clear in the same cycle
        int_status <= (int_status & ~(wr_clr ? wr_word[2:0] : 3'h0))
            | events;
        if (pop)
            buffer_full <= 1'b0;
        if (load) begin
            buffer_full <= 1'b1;
            received_data_register <= frame_data[7:0];
            framing_error_flag <= stop_bad;
            received_ninth_bit <= nine_bit_receive_select &
                frame_data[8];
        end
        // Overrun holds reception off until enable is dropped
        if (!continuous_receive_enable)
            overrun_error_flag <= 1'b0;
        else if (overrun)
            overrun_error_flag <= 1'b1;
    end
end

// ----------------------------------------------------------------
// Pins and interrupt
// ----------------------------------------------------------------
always @(posedge aclk) begin
    if (!aresetn) begin
        transmit_pin <= 1'b1;
        transmit_pin_oe <= 1'b0;
        irq <= 1'b0;
        irq_high_priority <= 1'b0;
    end else begin
        // No transmitter here: the pin idles at its mark level
        transmit_pin <= 1'b1 ^ transmit_polarity_invert;
        transmit_pin_oe <= port_enable && !sync_mode_select;
        irq <= global_interrupt_enable &&
            ((receive_complete_flag && receive_interrupt_enable) ||
            |(int_status[2:1] & int_enable[2:1]));
        irq_high_priority <= receive_priority;
    end
end

endmodule // async_receiver_address_detect
`default_nettype wire

// ==== verilog/baud_tick_gen.v ====
// Sixteen-times bit-rate tick generator
`timescale 1ns/1ps
`default_nettype none
`include "rx_addr_defines.vh"

module baud_tick_gen (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Configuration
    input wire enable,
    input wire [15:0] divisor,
    input wire high_speed,
    input wire wide,
    // Tick out
    output reg tick
);

reg [17:0] count;
wire [15:0] n = wide ? divisor : {8'h00, divisor[7:0]};
// Low-speed 8-bit divisor runs four times slower
wire [17:0] reload = (!high_speed && !wide) ?
    (({2'b00, n} + 18'h00001) << `LOW_SPEED_SCALE) - 18'h00001 :
    {2'b00, n};

always @(posedge aclk) begin
    if (!aresetn || !enable) begin
        count <= 18'h00000;
        tick <= 1'b0;
    end else if (count == 18'h00000) begin
        count <= reload;
        tick <= 1'b1;
    end else begin
        count <= count - 18'h00001;
        tick <= 1'b0;
    end
end

endmodule // baud_tick_gen
`default_nettype wire

// ==== verilog/rx_addr_defines.vh ====
// Register offsets, field positions and reset values of the receiver
`ifndef RX_ADDR_DEFINES_VH
`define RX_ADDR_DEFINES_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_STATUS_CONTROL 8'h00
`define OFS_RX_DATA 8'h04
`define OFS_BAUD_CONFIG 8'h08
`define OFS_INT_CONTROL 8'h0C
`define OFS_INT_STATUS 8'h10
`define OFS_INT_CLEAR 8'h14
`define OFS_INT_ENABLE 8'h18

// ----------------------------------------------------------------
// receive_status_control fields
// ----------------------------------------------------------------
`define BIT_PORT_ENABLE 7
`define BIT_NINE_BIT 6
`define BIT_SINGLE_RX 5
`define BIT_CONT_RX 4
`define BIT_ADDR_DETECT 3
`define BIT_FRAMING_ERR 2
`define BIT_OVERRUN_ERR 1
`define BIT_NINTH 0
`define STATUS_CONTROL_RESET 8'h00

// ----------------------------------------------------------------
// baud_config fields
// ----------------------------------------------------------------
`define BIT_HIGH_SPEED 16
`define BIT_WIDE_DIVISOR 17
`define BIT_RX_INVERT 18
`define BIT_TX_INVERT 19
`define BIT_SYNC_MODE 20
`define BAUD_CONFIG_RESET 21'h00000

// ----------------------------------------------------------------
// Interrupt control and event bits
// ----------------------------------------------------------------
`define BIT_GLOBAL_IE 0
`define BIT_RX_PRIORITY 1
`define EV_RX_COMPLETE 0
`define EV_FRAMING 1
`define EV_OVERRUN 2
`define EV_RESET 3'h0

// ----------------------------------------------------------------
// Oversampling and bus answers
// ----------------------------------------------------------------
`define SAMPLE_A 4'h7
`define SAMPLE_B 4'h8
`define SAMPLE_C 4'h9
`define SAMPLE_LAST 4'hF
`define LOW_SPEED_SCALE 2
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ==== verilog/rx_frame_shifter.v ====
// Oversampling data recovery and receive shift register
`timescale 1ns/1ps
`default_nettype none
`include "rx_addr_defines.vh"

module rx_frame_shifter (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Control
    input wire enable,
    input wire tick16,
    input wire invert,
    input wire nine_bit,
    // Line
    input wire receive_pin,
    // Frame out
    output reg frame_done,
    output reg [8:0] frame_data,
    output reg stop_bad
);

localparam [3:0] S_IDLE = 4'h1;
localparam [3:0] S_START = 4'h2;
localparam [3:0] S_DATA = 4'h4;
localparam [3:0] S_STOP = 4'h8;

reg sync1, sync2;
reg [3:0] state;
reg [3:0] sub;
reg [3:0] bits;
reg vote_a, vote_b;
reg [8:0] receive_shift_register;

function maj3;
    input a, b, c;
    begin
        maj3 = (a & b) | (a & c) | (b & c);
    end
endfunction

wire line = sync2 ^ invert;
wire bit_val = maj3(vote_a, vote_b, line);
wire mid = tick16 && (sub == `SAMPLE_C);
wire [3:0] last_bit = nine_bit ? 4'h8 : 4'h7;

always @(posedge aclk) begin
    if (!aresetn) begin
        sync1 <= 1'b1;
        sync2 <= 1'b1;
    end else begin
        sync1 <= receive_pin;
        sync2 <= sync1;
    end
end

// Start, data and stop states count ticks at 16 per bit; idle holds the count at zero
always @(posedge aclk) begin
    frame_done <= 1'b0;
    if (!aresetn || !enable) begin
        state <= S_IDLE;
        sub <= 4'h0;
        bits <= 4'h0;
        vote_a <= 1'b1;
        vote_b <= 1'b1;
        receive_shift_register <= 9'h000;
        frame_data <= 9'h000;
        stop_bad <= 1'b0;
    end else begin
        if (tick16) begin
            sub <= sub + 4'h1;
            if (sub == `SAMPLE_A)
                vote_a <= line;
            if (sub == `SAMPLE_B)
                vote_b <= line;
        end
        case (state)
            S_IDLE: begin
                sub <= 4'h0;
                bits <= 4'h0;
                if (!line)
                    state <= S_START;
            end
            S_START: begin
                // Glitch shorter than half a bit is rejected
                if (mid && bit_val)
                    state <= S_IDLE;
                else if (tick16 && sub == `SAMPLE_LAST)
                    state <= S_DATA;
            end
            S_DATA: begin
                if (mid)
                    receive_shift_register <=
                        {bit_val, receive_shift_register[8:1]};
                if (tick16 && sub == `SAMPLE_LAST) begin
                    bits <= bits + 4'h1;
                    if (bits == last_bit)
                        state <= S_STOP;
                end
            end
            S_STOP: begin
                // Leave at mid stop bit to resync on the next start
                if (mid) begin
                    frame_done <= 1'b1;
                    stop_bad <= !bit_val;
                    frame_data <= nine_bit ? receive_shift_register :
                        {1'b0, receive_shift_register[8:1]};
                    state <= S_IDLE;
                end
            end
            default: state <= S_IDLE;
        endcase
    end
end

endmodule // rx_frame_shifter
`default_nettype wire
